// >>> sim/fcsp_far_model.sv
// Far side: host register cycles, channel pins and power stage sensors.
// Assumes clk_in from the bench; every signal changes on the falling edge.
`timescale 1ns/1ps
module fcsp_far_model (
  input  wire logic       clk_in,   // Block clock
  output logic            wr_out,   // Write strobe
  output logic            rd_out,   // Read strobe
  output logic            bank_out, // register_bank_select
  output logic [1:0]      addr_out, // Bank 1 address
  output logic [5:0]      data_out, // Write data
  output logic            diag_out, // Diagnosis word shifted out
  output logic [4:0]      pin_out,  // channel_input_pin
  output logic [4:0]      ot_out,   // Over temperature
  output logic [4:0]      cool_out, // Cooled past hysteresis
  output logic [4:0]      dyn_out,  // Dynamic cutoff
  output logic [4:0]      ol_out,   // Over load
  output logic [4:0]      ic_out    // Inverse current
);
  initial {wr_out, rd_out, bank_out, addr_out, data_out, diag_out} = '0;
  initial {pin_out, ot_out, cool_out, dyn_out, ol_out, ic_out} = '0;
  // Spare switch bit is never sent as 1, it only costs supply current
  task automatic cyc(input logic w, input logic b, input logic [1:0] a, input logic [5:0] d);
    @(negedge clk_in);
    {wr_out, rd_out, bank_out, addr_out} = {w, !w, b, a};
    data_out = b ? d : {1'b0, d[4:0]};
    @(negedge clk_in);
    {wr_out, rd_out} = 2'b00;
  endtask
  // Write the switch bits, then read them back in the very next cycle
  task automatic wr_then_rd(input logic [4:0] d);
    @(negedge clk_in);
    {wr_out, rd_out, bank_out, data_out} = {1'b1, 1'b0, 1'b0, 1'b0, d};
    @(negedge clk_in);
    {wr_out, rd_out} = 2'b01;
    @(negedge clk_in);
    rd_out = 1'b0;
  endtask
  task automatic diag();
    @(negedge clk_in);
    diag_out = 1'b1;
    @(negedge clk_in);
    diag_out = 1'b0;
  endtask
endmodule // fcsp_far_model

// >>> sim/fcsp_top_tb_top.sv
// Self-checking bench for the switch protection block.
// Assumes the far side model drives every host and sensor input.
`timescale 1ns/1ps
module fcsp_top_tb_top;
  logic        clk_in, rst_n_in, wr, rd, bank, diag;
  logic [1:0]  addr;
  logic [5:0]  wdat, rd_data_out;
  logic [4:0]  pin, ot, cool, dyn, ol, ic, drive_out, latch_out, err_out;
  logic [31:0] seed, r;
  int          fails, comparisons;
  fcsp_far_model far_i (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .bank_out(bank),
    .addr_out(addr), .data_out(wdat), .diag_out(diag), .pin_out(pin), .ot_out(ot),
    .cool_out(cool), .dyn_out(dyn), .ol_out(ol), .ic_out(ic));
  fcsp_top fcsp_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr), .rd_en_in(rd),
    .bank_in(bank), .addr_in(addr), .wr_data_in(wdat), .diag_read_in(diag),
    .channel_input_pin_in(pin), .over_temp_in(ot), .temp_cool_in(cool), .dyn_temp_in(dyn),
    .over_load_in(ol), .inv_cur_in(ic), .rd_data_out(rd_data_out), .drive_out(drive_out),
    .latch_out(latch_out), .err_flags_out(err_out));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [5:0] exp_drive(input logic [4:0] o, p, input logic pwm);
    return {1'b0, pwm ? (o & p) : (o | p)};
  endfunction
  task automatic cmp(input string what, input logic [5:0] exp, input logic [5:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Sensors pass two synchroniser stages and the channel register
  task automatic settle();
    repeat (4) @(negedge clk_in);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial begin
    seed = 32'hb6cd;
    fails = 0;
    comparisons = 0;
    rst_n_in = 1'b0;
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    cmp("reset", 6'h00, {1'b0, drive_out | latch_out | err_out} | rd_data_out);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      r[9] = i[0];
      far_i.cyc(1'b1, 1'b0, 2'h0, r[5:0]);
      far_i.cyc(1'b1, 1'b1, 2'h1, {2'h0, r[9], 3'h0});
      far_i.pin_out = r[14:10];
      settle();
      cmp("drive", exp_drive(r[4:0], r[14:10], r[9]), {1'b0, drive_out});
      far_i.cyc(1'b0, 1'b0, 2'h0, 6'h00);
      cmp("switch_rd", {1'b0, r[4:0]}, {1'b0, rd_data_out[4:0]});
      far_i.cyc(1'b0, 1'b1, 2'h1, 6'h00);
      cmp("cfg_rd", {2'h0, r[9], 3'h0}, {2'h0, rd_data_out[3:0]});
      far_i.wr_then_rd(r[19:15]);
      cmp("wr_rd", {1'b0, r[19:15]}, rd_data_out);
    end
    $display("done combine");
    far_i.cyc(1'b1, 1'b0, 2'h0, 6'h1f);
    far_i.cyc(1'b1, 1'b1, 2'h1, 6'h00);
    far_i.pin_out = 5'h00;
    far_i.ot_out = 5'h12;
    settle();
    cmp("latch", 6'h12, {1'b0, latch_out});
    cmp("err_ot", 6'h12, {1'b0, err_out});
    far_i.ot_out = 5'h00;
    settle();
    cmp("drive_lat", 6'h0d, {1'b0, drive_out});
    far_i.cyc(1'b1, 1'b1, 2'h0, 6'h01);
    settle();
    cmp("hot_clr", 6'h12, {1'b0, latch_out});
    far_i.cool_out = 5'h1f;
    far_i.cyc(1'b1, 1'b1, 2'h0, 6'h00);
    settle();
    cmp("zero_clr", 6'h12, {1'b0, latch_out});
    far_i.cyc(1'b1, 1'b1, 2'h0, 6'h01);
    settle();
    cmp("clr_all", 6'h00, {1'b0, latch_out});
    cmp("drive_back", 6'h1f, {1'b0, drive_out});
    $display("done thermal");
    far_i.diag();
    far_i.dyn_out = 5'h04;
    settle();
    cmp("drive_dyn", 6'h1b, {1'b0, drive_out});
    cmp("err_dyn", 6'h04, {1'b0, err_out});
    far_i.diag();
    settle();
    cmp("err_again", 6'h04, {1'b0, err_out});
    far_i.dyn_out = 5'h00;
    settle();
    far_i.diag();
    settle();
    cmp("err_read", 6'h00, {1'b0, err_out});
    far_i.ol_out = 5'h01;
    settle();
    far_i.ol_out = 5'h00;
    settle();
    cmp("err_ol", 6'h01, {1'b0, err_out});
    far_i.diag();
    settle();
    cmp("err_ol_clr", 6'h00, {1'b0, err_out});
    $display("done diagnosis");
    far_i.ic_out = 5'h08;
    far_i.ol_out = 5'h08;
    settle();
    cmp("err_ic", 6'h00, {1'b0, err_out});
    far_i.cyc(1'b1, 1'b0, 2'h0, 6'h00);
    settle();
    cmp("drive_ic", 6'h08, {1'b0, drive_out});
    $display("done inverse");
    tally_and_finish();
  end
endmodule // fcsp_top_tb_top

// >>> verilog/fcsp_chan.sv
// One switch channel: thermal latch, drive gating and error flag.
// Assumes all protection inputs are already synchronised to clk_in.
`timescale 1ns/1ps
module fcsp_chan (
  input  wire logic clk_in,          // 200 MHz clock
  input  wire logic rst_n_in,        // Synchronous reset, active low
  input  wire logic req_in,          // Combined on request
  input  wire logic over_temp_in,    // Over-temperature indication
  input  wire logic temp_cool_in,    // Temperature back below threshold minus hysteresis
  input  wire logic latch_clear_in,  // Clear-all thermal latch command pulse
  input  wire logic dyn_temp_in,     // Dynamic temperature cutoff active
  input  wire logic over_load_in,    // Over-load indication
  input  wire logic inv_cur_in,      // Inverse current present
  input  wire logic err_clear_in,    // Diagnosis word shifted out
  output logic      drive_out,       // Final channel drive
  output logic      latch_out,       // Thermal latch state
  output logic      err_out          // Error flag
);
  logic drive_reg, drive_next;
  logic latch_reg, latch_next;
  logic err_reg, err_next;

  always_comb begin
    latch_next = latch_reg;
    if (over_temp_in) begin
      latch_next = 1'b1;
    end else if (latch_clear_in && temp_cool_in) begin
      latch_next = 1'b0;
    end
    // Inverse current freezes the drive unless thermal shutdown steps in
    if (inv_cur_in && !over_temp_in) begin
      drive_next = drive_reg;
    end else begin
      drive_next = req_in && !latch_next && !dyn_temp_in;
    end
    // A pending cause sets again over the read clear; inverse current forces the flag to 0
    err_next = (err_reg && !err_clear_in) || dyn_temp_in;
    err_next = err_next || over_load_in || latch_next;
    if (inv_cur_in) begin
      err_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      drive_reg <= 1'b0;
      latch_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      drive_reg <= drive_next;
      latch_reg <= latch_next;
      err_reg   <= err_next;
    end
  end

  assign drive_out = drive_reg;
  assign latch_out = latch_reg;
  assign err_out   = err_reg;

  a_latch_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    over_temp_in |=> latch_reg && !drive_reg) else $error("thermal latch not set");
  a_latch_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    latch_reg && !(latch_clear_in && temp_cool_in) |=> latch_reg) else $error("latch released");
  a_dyn_cutoff: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dyn_temp_in && !inv_cur_in |=> !drive_reg && err_reg) else $error("dynamic cutoff missed");
  a_err_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    err_clear_in && dyn_temp_in && !inv_cur_in |=> err_reg) else $error("error flag lost");
  a_inv_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    inv_cur_in && !over_temp_in |=> $stable(drive_reg)) else $error("drive moved on inverse");
  a_inv_err: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    inv_cur_in |=> !err_reg) else $error("error flag kept on inverse");
endmodule // fcsp_chan

// >>> verilog/fcsp_pkg.sv
// Constants for the five-channel switch protection block.
// Assumes the serial framing logic decodes bank, address and data on clk_in.
package fcsp_pkg;
  localparam int          NUM_CH      = 5;
  localparam int          OUT_W       = 6;
  localparam int          CFG_W       = 4;
  localparam int          SYNC_W      = 6 * NUM_CH;
  localparam logic        BANK_OUT    = 1'h0;
  localparam logic        BANK_CFG    = 1'h1;
  localparam logic [1:0]  ADDR_HWCMD  = 2'h0;
  localparam logic [1:0]  ADDR_PCFG   = 2'h1;
  localparam int          PWM_BIT     = 3;
  localparam int          CLR_BIT     = 0;
  localparam int          SPARE_BIT   = 5;
  localparam logic [5:0]  OUT_RST     = 6'h00;
  localparam logic [3:0]  CFG_RST     = 4'h0;
  localparam logic [5:0]  DATA_ZERO   = 6'h00;
endpackage

// >>> verilog/fcsp_top.sv
// Register file and five protected switch channels.
// Assumes serial framing on clk_in supplies one-cycle write/read strobes.
`timescale 1ns/1ps
module fcsp_top #(
  parameter int NUM_CH = fcsp_pkg::NUM_CH  // Channel count
) (
  input  wire logic              clk_in,            // 200 MHz clock
  input  wire logic              rst_n_in,          // Synchronous reset, active low
  input  wire logic              wr_en_in,          // Register write strobe
  input  wire logic              rd_en_in,          // Register read strobe
  input  wire logic              bank_in,           // register_bank_select
  input  wire logic [1:0]        addr_in,           // Address within bank 1
  input  wire logic [5:0]        wr_data_in,        // Write data
  input  wire logic              diag_read_in,      // Diagnosis word shifted out
  input  wire logic [NUM_CH-1:0] channel_input_pin_in, // Per-channel input pins
  input  wire logic [NUM_CH-1:0] over_temp_in,      // Over-temperature sensors
  input  wire logic [NUM_CH-1:0] temp_cool_in,      // Cooled past hysteresis
  input  wire logic [NUM_CH-1:0] dyn_temp_in,       // Dynamic temperature cutoff
  input  wire logic [NUM_CH-1:0] over_load_in,      // Over-load monitors
  input  wire logic [NUM_CH-1:0] inv_cur_in,        // Inverse current detectors
  output logic      [5:0]        rd_data_out,       // Read data, registered
  output logic      [NUM_CH-1:0] drive_out,         // Channel drives
  output logic      [NUM_CH-1:0] latch_out,         // Thermal latch states
  output logic      [NUM_CH-1:0] err_flags_out      // Standard diagnosis error flags
);
  logic [5:0]          channel_on_request_reg, channel_on_request_next;
  logic [3:0]          input_combine_config_reg, input_combine_config_next;
  logic [5:0]          rd_data_reg, rd_data_next;
  logic [6*NUM_CH-1:0] sync1_reg, sync2_reg, raw_async;
  logic [NUM_CH-1:0]   pin_s, ot_s, cool_s, dyn_s, ol_s, inv_s;
  logic [NUM_CH-1:0]   req;
  logic                thermal_latch_clear;
  logic                wr_bank0, wr_bank1;

  // Every sensor and pin is asynchronous; only the second stage is read
  assign raw_async = {inv_cur_in, over_load_in, dyn_temp_in, temp_cool_in, over_temp_in,
                      channel_input_pin_in};
  assign pin_s  = sync2_reg[0*NUM_CH +: NUM_CH];
  assign ot_s   = sync2_reg[1*NUM_CH +: NUM_CH];
  assign cool_s = sync2_reg[2*NUM_CH +: NUM_CH];
  assign dyn_s  = sync2_reg[3*NUM_CH +: NUM_CH];
  assign ol_s   = sync2_reg[4*NUM_CH +: NUM_CH];
  assign inv_s  = sync2_reg[5*NUM_CH +: NUM_CH];

  assign wr_bank0 = wr_en_in && (bank_in == fcsp_pkg::BANK_OUT);
  assign wr_bank1 = wr_en_in && (bank_in == fcsp_pkg::BANK_CFG);
  // The command bit is a strobe: it is never stored, so it reads back 0
  assign thermal_latch_clear = wr_bank1 && (addr_in == fcsp_pkg::ADDR_HWCMD) &&
                               wr_data_in[fcsp_pkg::CLR_BIT];

  always_comb begin
    channel_on_request_next   = channel_on_request_reg;
    input_combine_config_next = input_combine_config_reg;
    rd_data_next              = rd_data_reg;
    if (wr_bank0) begin
      // Bit 5 is stored as written; it costs supply current only
      channel_on_request_next = wr_data_in;
    end
    if (wr_bank1 && (addr_in == fcsp_pkg::ADDR_PCFG)) begin
      input_combine_config_next = wr_data_in[3:0];
    end
    if (rd_en_in) begin
      if (bank_in == fcsp_pkg::BANK_OUT) begin
        rd_data_next = channel_on_request_reg;
      end else if (addr_in == fcsp_pkg::ADDR_PCFG) begin
        rd_data_next = {2'h0, input_combine_config_reg};
      end else begin
        rd_data_next = fcsp_pkg::DATA_ZERO;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      channel_on_request_reg   <= fcsp_pkg::OUT_RST;
      input_combine_config_reg <= fcsp_pkg::CFG_RST;
      rd_data_reg              <= fcsp_pkg::DATA_ZERO;
      sync1_reg                <= '0;
      sync2_reg                <= '0;
    end else begin
      channel_on_request_reg   <= channel_on_request_next;
      input_combine_config_reg <= input_combine_config_next;
      rd_data_reg              <= rd_data_next;
      sync1_reg                <= raw_async;
      sync2_reg                <= sync1_reg;
    end
  end

  assign rd_data_out = rd_data_reg;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      always_comb begin
        if (input_combine_config_reg[fcsp_pkg::PWM_BIT]) begin
          req[ch] = channel_on_request_reg[ch] && pin_s[ch];
        end else begin
          req[ch] = channel_on_request_reg[ch] || pin_s[ch];
        end
      end

      fcsp_chan fcsp_chan_i (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .req_in         (req[ch]),
        .over_temp_in   (ot_s[ch]),
        .temp_cool_in   (cool_s[ch]),
        .latch_clear_in (thermal_latch_clear),
        .dyn_temp_in    (dyn_s[ch]),
        .over_load_in   (ol_s[ch]),
        .inv_cur_in     (inv_s[ch]),
        .err_clear_in   (diag_read_in),
        .drive_out      (drive_out[ch]),
        .latch_out      (latch_out[ch]),
        .err_out        (err_flags_out[ch])
      );

      a_or_combine: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !input_combine_config_reg[fcsp_pkg::PWM_BIT] && !latch_out[ch] && pin_s[ch] &&
        !ot_s[ch] && !dyn_s[ch] && !inv_s[ch] |=> drive_out[ch])
        else $error("or combine failed");
      a_and_combine: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        input_combine_config_reg[fcsp_pkg::PWM_BIT] && !pin_s[ch] && !inv_s[ch]
        |=> !drive_out[ch])
        else $error("and combine failed");
      a_clear_all: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        thermal_latch_clear && cool_s[ch] && !ot_s[ch] |=> !latch_out[ch])
        else $error("latch not cleared");
      a_latch_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        latch_out[ch] |-> !drive_out[ch])
        else $error("latched channel driven");
      a_ol_err: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ol_s[ch] && !inv_s[ch] |=> err_flags_out[ch])
        else $error("over-load not flagged");
    end
  endgenerate

  a_out_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_bank0 ##1 (rd_en_in && bank_in == fcsp_pkg::BANK_OUT && !wr_en_in)
    |=> rd_data_out == $past(wr_data_in, 2))
    else $error("switch bits readback wrong");
  a_err_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    diag_read_in && (ot_s | dyn_s | ol_s | latch_out) == '0 |=> err_flags_out == '0)
    else $error("error flags not cleared");
endmodule // fcsp_top
